//--- lpm_defines.vh
// register offsets, field positions, panel type codes, reset values and gpio pin count for the panel pin mux
// assumes inclusion by bare name from the pin mux design files
`ifndef LPM_DEFINES_VH
`define LPM_DEFINES_VH

// register byte offsets, one aligned word each
`define LPM_CFG_OFS        12'h000
`define LPM_GPIO_DIR_OFS   12'h064
`define LPM_GPIO_OUT_OFS   12'h068
`define LPM_GPIO_IN_OFS    12'h06c
`define LPM_STATUS_OFS     12'h070

// configuration register fields
`define LPM_CFG_TYPE_LSB   0
`define LPM_CFG_TYPE_MSB   1
`define LPM_CFG_FMT1_BIT   2
`define LPM_CFG_ENMODE_BIT 3
`define LPM_CFG_GPOVAL_BIT 4
`define LPM_CFG_OUTEN_BIT  5

// panel type codes
`define LPM_TYPE_PASSIVE   2'h0
`define LPM_TYPE_TFT       2'h1
`define LPM_TYPE_DIRECT    2'h2

// reset values
`define LPM_CFG_RST        6'h00
`define LPM_GPIO_DIR_RST   3'h0
`define LPM_GPIO_OUT_RST   3'h0

// general-purpose pin count
`define LPM_GPIO_NUM       3

`endif

//--- lpm_sync2.v
// two-stage synchroniser for a single level from outside the clock domain
// assumes the input is asynchronous to clk_sys; output lags by two edges
module lpm_sync2 (
    // clock and reset
    input  wire clk_sys,
    input  wire rstn,
    // level in and out
    input  wire asyncIn,
    output wire syncOut
);

    reg stageOne_ff;
    reg stageTwo_ff;

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            stageOne_ff <= 1'b0;
            stageTwo_ff <= 1'b0;
        end else begin
            stageOne_ff <= asyncIn;
            stageTwo_ff <= stageOne_ff;
        end
    end

    assign syncOut = stageTwo_ff;

endmodule

//--- lpm_pin_mux.v
// panel pin function mux: routes pixel bus, strobes, enable pin and gpio 0-2 per panel type
// assumes an apb master on clk_sys and a timing generator whose strobes arrive asynchronously
//
// Contract
// - drive the 18-bit pixel bus, all bits low during reset.
// - frame sync carries frame pulse, or start pulse in direct mode.
// - line sync carries line pulse, or latch pulse in direct mode.
// - shift output carries shift clock, or source clock in direct mode.
// - enable pin gives data valid for tft, or acts as plain output.
// - passive format 1 panels get a second shift clock on the enable pin.
// - all other panel types except tft get the backplane bias signal on the enable pin.
// - gpio 0 is plain io, or power-save control in direct mode.
// - gpio 0 floats during reset and is input after release.
// - gpio 1 is plain io, or gate-driver clock in direct mode.
// - gpio 1 floats during reset and is input after release.
// - gpio 2 is plain io, or polarity reversal in direct mode.
// - gpio 2 floats during reset and is input after release.
`include "lpm_defines.vh"

module lpm_pin_mux (
    // clock and reset
    input  wire        clk_sys,
    input  wire        rstn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    // timing generator inputs, asynchronous
    input  wire [17:0] pixelDataIn,
    input  wire        framePulseIn,
    input  wire        linePulseIn,
    input  wire        shiftClockIn,
    input  wire        dataValidIn,
    input  wire        secondShiftIn,
    input  wire        backplaneBiasIn,
    input  wire        directStartPulseIn,
    input  wire        directLatchPulseIn,
    input  wire        sourceClockIn,
    input  wire        panelPowerSaveIn,
    input  wire        gateDriverClockIn,
    input  wire        polarityReversalIn,
    // panel pins
    output reg  [17:0] panelPixelBus,
    output reg         frameSyncOut,
    output reg         lineSyncOut,
    output reg         pixelShiftOut,
    output reg         multiEnableOut,
    // general-purpose pins, three signals each
    input  wire [2:0]  gpioPinIn,
    output reg  [2:0]  gpioPinOut,
    output reg  [2:0]  gpioPinOe
);

    // configuration and gpio state
    reg  [5:0]  cfg_ff;
    reg  [2:0]  gpioDir_ff;
    reg  [2:0]  gpioOut_ff;
    reg  [2:0]  gpioInSync_ff;
    reg  [2:0]  gpioInMeta_ff;

    wire [1:0]  panelType  = cfg_ff[`LPM_CFG_TYPE_MSB:`LPM_CFG_TYPE_LSB];
    wire        fmtOne     = cfg_ff[`LPM_CFG_FMT1_BIT];
    wire        enableGpo  = cfg_ff[`LPM_CFG_ENMODE_BIT];
    wire        gpoValue   = cfg_ff[`LPM_CFG_GPOVAL_BIT];
    wire        outEnable  = cfg_ff[`LPM_CFG_OUTEN_BIT];
    wire        directMode = (panelType == `LPM_TYPE_DIRECT);

    // apb decode: zero wait state, unmapped reads zero with error
    wire        apbAccess  = psel & penable;
    wire        apbWrite   = apbAccess & pwrite;
    wire        hitCfg     = (paddr == `LPM_CFG_OFS);
    wire        hitDir     = (paddr == `LPM_GPIO_DIR_OFS);
    wire        hitOut     = (paddr == `LPM_GPIO_OUT_OFS);
    wire        hitIn      = (paddr == `LPM_GPIO_IN_OFS);
    wire        hitStat    = (paddr == `LPM_STATUS_OFS);
    wire        hitAny     = hitCfg | hitDir | hitOut | hitIn | hitStat;

    assign pready  = 1'b1;
    assign pslverr = apbAccess & ~hitAny;

    // type and format only change while output is off; avoids glitching a live panel
    wire        cfgLocked  = outEnable;

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cfg_ff     <= `LPM_CFG_RST;
            gpioDir_ff <= `LPM_GPIO_DIR_RST;
            gpioOut_ff <= `LPM_GPIO_OUT_RST;
        end else begin
            if (apbWrite && hitCfg) begin
                if (cfgLocked) begin
                    cfg_ff[`LPM_CFG_ENMODE_BIT] <= pwdata[`LPM_CFG_ENMODE_BIT];
                    cfg_ff[`LPM_CFG_GPOVAL_BIT] <= pwdata[`LPM_CFG_GPOVAL_BIT];
                    cfg_ff[`LPM_CFG_OUTEN_BIT]  <= pwdata[`LPM_CFG_OUTEN_BIT];
                end else begin
                    cfg_ff <= pwdata[5:0];
                end
            end
            if (apbWrite && hitDir) begin
                gpioDir_ff <= pwdata[2:0];
            end
            if (apbWrite && hitOut) begin
                gpioOut_ff <= pwdata[2:0];
            end
        end
    end

    always @* begin
        prdata = 32'h0000_0000;
        if (hitCfg) begin
            prdata[5:0] = cfg_ff;
        end else if (hitDir) begin
            prdata[2:0] = gpioDir_ff;
        end else if (hitOut) begin
            prdata[2:0] = gpioOut_ff;
        end else if (hitIn) begin
            prdata[2:0] = gpioInSync_ff;
        end else if (hitStat) begin
            prdata[0] = directMode;
            prdata[1] = outEnable;
            prdata[4:2] = gpioPinOe;
        end
    end

    // gpio input synchronisers, one two-flop vector for all three pins
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            gpioInMeta_ff <= 3'h0;
            gpioInSync_ff <= 3'h0;
        end else begin
            gpioInMeta_ff <= gpioPinIn;
            gpioInSync_ff <= gpioInMeta_ff;
        end
    end

    // strobe and pixel synchronisers
    wire [17:0] pixelSync;
    wire [12:0] strobeSync;
    wire [12:0] strobeRaw = {polarityReversalIn, gateDriverClockIn, panelPowerSaveIn,
                             sourceClockIn, directLatchPulseIn, directStartPulseIn,
                             backplaneBiasIn, secondShiftIn, dataValidIn,
                             shiftClockIn, linePulseIn, framePulseIn, 1'b0};

    genvar gi;
    generate
        for (gi = 0; gi < 18; gi = gi + 1) begin : gPix
            lpm_sync2 uPixSync (
                .clk_sys (clk_sys),
                .rstn    (rstn),
                .asyncIn (pixelDataIn[gi]),
                .syncOut (pixelSync[gi])
            );
        end
        for (gi = 1; gi < 13; gi = gi + 1) begin : gStb
            lpm_sync2 uStbSync (
                .clk_sys (clk_sys),
                .rstn    (rstn),
                .asyncIn (strobeRaw[gi]),
                .syncOut (strobeSync[gi])
            );
        end
    endgenerate
    assign strobeSync[0] = 1'b0;

    wire sFrame   = strobeSync[1];
    wire sLine    = strobeSync[2];
    wire sShift   = strobeSync[3];
    wire sValid   = strobeSync[4];
    wire sShift2  = strobeSync[5];
    wire sBias    = strobeSync[6];
    wire sStart   = strobeSync[7];
    wire sLatch   = strobeSync[8];
    wire sSrcClk  = strobeSync[9];
    wire sPwrSave = strobeSync[10];
    wire sGateClk = strobeSync[11];
    wire sPolRev  = strobeSync[12];

    // next values of the panel pins
    reg  [17:0] nxt_pixel;
    reg         nxt_frame;
    reg         nxt_line;
    reg         nxt_shift;
    reg         nxt_enable;
    reg  [2:0]  nxt_gpioOut;
    reg  [2:0]  nxt_gpioOe;
    reg  [2:0]  altFunc;

    always @* begin
        nxt_pixel  = outEnable ? pixelSync : 18'h00000;
        nxt_frame  = 1'b0;
        nxt_line   = 1'b0;
        nxt_shift  = 1'b0;
        nxt_enable = 1'b0;
        if (outEnable) begin
            nxt_frame = directMode ? sStart  : sFrame;
            nxt_line  = directMode ? sLatch  : sLine;
            nxt_shift = directMode ? sSrcClk : sShift;
        end
        // gpo mode works even with panel output off
        if (enableGpo) begin
            nxt_enable = gpoValue;
        end else if (outEnable) begin
            case (panelType)
                `LPM_TYPE_TFT: begin
                    nxt_enable = sValid;
                end
                `LPM_TYPE_PASSIVE: begin
                    nxt_enable = fmtOne ? sShift2 : sBias;
                end
                default: begin
                    nxt_enable = sBias;
                end
            endcase
        end
    end

    // gpio pins: function select, direction register always gates the driver
    always @* begin
        altFunc     = {sPolRev, sGateClk, sPwrSave};
        nxt_gpioOe  = gpioDir_ff;
        nxt_gpioOut = (directMode && outEnable) ? altFunc : gpioOut_ff;
    end

    // panel and gpio pins registered; reset drives panel low, gpio undriven
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            panelPixelBus  <= 18'h00000;
            frameSyncOut   <= 1'b0;
            lineSyncOut    <= 1'b0;
            pixelShiftOut  <= 1'b0;
            multiEnableOut <= 1'b0;
            gpioPinOut     <= 3'h0;
            gpioPinOe      <= 3'h0;
        end else begin
            panelPixelBus  <= nxt_pixel;
            frameSyncOut   <= nxt_frame;
            lineSyncOut    <= nxt_line;
            pixelShiftOut  <= nxt_shift;
            multiEnableOut <= nxt_enable;
            gpioPinOut     <= nxt_gpioOut;
            gpioPinOe      <= nxt_gpioOe;
        end
    end

endmodule

//--- lpm_pin_mux_asserts.sv
// port-level checks for the panel pin mux
// assumes config is mirrored from apb writes seen at the ports
`include "lpm_defines.vh"
module lpm_pin_mux_chk (
    // clock, reset, apb
    input wire        clk_sys, rstn, psel, penable, pwrite, pready, pslverr,
    input wire [11:0] paddr,
    input wire [31:0] pwdata, prdata,
    // timing inputs and panel pins
    input wire [17:0] pixelDataIn, panelPixelBus,
    input wire        framePulseIn, linePulseIn, shiftClockIn, dataValidIn, secondShiftIn,
    input wire        backplaneBiasIn, directStartPulseIn, directLatchPulseIn, sourceClockIn,
    input wire        panelPowerSaveIn, gateDriverClockIn, polarityReversalIn,
    input wire        frameSyncOut, lineSyncOut, pixelShiftOut, multiEnableOut,
    input wire [2:0]  gpioPinOut, gpioPinOe
);
    reg  [5:0] cfg_ff;
    reg  [2:0] dir_ff;
    reg  [2:0] gpo_ff;
    wire       wr = psel && penable && pwrite;
    wire       dm = cfg_ff[1:0] == `LPM_TYPE_DIRECT;
    wire       dmOn = dm && cfg_ff[5];
    wire       tft = cfg_ff[1:0] == `LPM_TYPE_TFT;
    wire       fmt1 = cfg_ff[2:0] == 3'h4;
    wire       mapped = paddr inside {12'h000, 12'h064, 12'h068, 12'h06c, 12'h070};
    // type and format bits frozen while output is on
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cfg_ff <= 6'h00;
            dir_ff <= 3'h0;
            gpo_ff <= 3'h0;
        end else if (wr) begin
            if (paddr == `LPM_CFG_OFS)
                cfg_ff <= cfg_ff[5] ? {pwdata[5:3], cfg_ff[2:0]} : pwdata[5:0];
            if (paddr == `LPM_GPIO_DIR_OFS)
                dir_ff <= pwdata[2:0];
            if (paddr == `LPM_GPIO_OUT_OFS)
                gpo_ff <= pwdata[2:0];
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    a_reset_low: assert property (disable iff (1'b0) !rstn |-> panelPixelBus == 18'h0
        && !frameSyncOut && !lineSyncOut && !pixelShiftOut && !multiEnableOut)
        else $error("panel pins not low in reset");
    a_reset_float: assert property (disable iff (1'b0) !rstn |-> gpioPinOe == 3'h0)
        else $error("gpio driven in reset");
    a_oe_dir: assert property (gpioPinOe == $past(dir_ff))
        else $error("gpio enable not direction");
    a_apb_answer: assert property (psel && penable |-> pready && pslverr == !mapped
        && (mapped || prdata == 32'h0)) else $error("apb answer wrong");
    a_pixel_pass: assert property (panelPixelBus ==
        ($past(cfg_ff[5]) ? $past(pixelDataIn, 3) : 18'h0)) else $error("pixel bus wrong");
    a_strobe_mux: assert property ($past(cfg_ff[5]) |->
        frameSyncOut == ($past(dm) ? $past(directStartPulseIn, 3) : $past(framePulseIn, 3))
        && lineSyncOut == ($past(dm) ? $past(directLatchPulseIn, 3) : $past(linePulseIn, 3)))
        else $error("sync strobe wrong");
    a_shift_mux: assert property ($past(cfg_ff[5]) |-> pixelShiftOut ==
        ($past(dm) ? $past(sourceClockIn, 3) : $past(shiftClockIn, 3)))
        else $error("shift output wrong");
    a_enable_mux: assert property (multiEnableOut == ($past(cfg_ff[3]) ? $past(cfg_ff[4])
        : !$past(cfg_ff[5]) ? 1'b0 : $past(tft) ? $past(dataValidIn, 3)
        : $past(fmt1) ? $past(secondShiftIn, 3) : $past(backplaneBiasIn, 3)))
        else $error("enable pin wrong");
    a_gpio_func: assert property (gpioPinOut == ($past(dmOn) ? {$past(polarityReversalIn, 3),
        $past(gateDriverClockIn, 3), $past(panelPowerSaveIn, 3)} : $past(gpo_ff)))
        else $error("gpio drive wrong");
    c_direct: cover property ($past(dmOn));
    c_locked: cover property (wr && paddr == `LPM_CFG_OFS && cfg_ff[5]);
    c_error: cover property (psel && penable && pslverr);
endmodule
bind lpm_pin_mux lpm_pin_mux_chk lpm_pin_mux_chk_i (.*);

//--- lpm_panel_model.sv
// panel side: resolves the gpio wires and counts shift clock rising edges
// assumes bench pins change after clk_sys edges
module lpm_panel_model (
    // clock
    input  wire       clk_sys,
    // pins
    input  wire       pixelShiftOut,
    input  wire [2:0] gpioPinOut, gpioPinOe, extVal, extEn,
    output wire [2:0] gpioPinIn,
    output wire [7:0] shiftCount
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [2:0] last_ff = 3'h0;
    reg [7:0] count_ff = 8'h00;
    reg       shiftD_ff = 1'b0;
    // no pull on these wires, so a float must never look stable
    assign gpioPinIn = gpioPinOe & gpioPinOut | ~gpioPinOe & (extEn & extVal | ~extEn & ~last_ff);
    assign shiftCount = count_ff;
    always @(posedge clk_sys) begin
        last_ff <= gpioPinIn;
        shiftD_ff <= pixelShiftOut;
        if (pixelShiftOut && !shiftD_ff)
            count_ff <= count_ff + 8'h01;
    end
endmodule

//--- lpm_pin_mux_bench.sv
// self-checking bench for the panel pin mux
// assumes a zero-wait apb slave and three-edge pin latency
`include "lpm_defines.vh"
module lpm_pin_mux_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // reset starts high and falls at time zero, so the async reset sees a real edge
    reg         clk_sys = 1'b0, rstn = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h0;
    reg  [17:0] pixelDataIn = 18'h0;
    reg         framePulseIn = 0, linePulseIn = 0, shiftClockIn = 0, dataValidIn = 0;
    reg         secondShiftIn = 0, backplaneBiasIn = 0, directStartPulseIn = 0;
    reg         directLatchPulseIn = 0, sourceClockIn = 0, polarityReversalIn = 0;
    reg         gateDriverClockIn = 0, panelPowerSaveIn = 0;
    reg  [2:0]  extVal = 3'h0, extEn = 3'h0;
    wire        pready, pslverr, frameSyncOut, lineSyncOut, pixelShiftOut, multiEnableOut;
    wire [31:0] prdata;
    wire [17:0] panelPixelBus;
    wire [2:0]  gpioPinIn, gpioPinOut, gpioPinOe;
    wire [7:0]  shiftCount;
    integer     fail_count = 0, samples_checked = 0, cyc = 0, m, k;
    reg  [31:0] q;
    reg  [11:0] v;
    reg  [5:0]  c;
    reg  [7:0]  sc0;
    reg         e, dm;
    reg  [5:0]  modes [0:5] = '{6'h20, 6'h24, 6'h21, 6'h22, 6'h23, 6'h39};
    lpm_pin_mux lpm_pin_mux_i (.*);
    lpm_panel_model lpm_panel_model_i (.*);
    always #20 clk_sys = ~clk_sys;
    task check(input string nm, input [31:0] s, input [31:0] x);
        samples_checked = samples_checked + 1;
        if (s !== x) begin
            fail_count = fail_count + 1;
            $display("CHECK FAILED %0s expected %h seen %h", nm, x, s);
        end
    endtask
    // one edge gap before setup, so the strobe is never assigned twice at one edge
    task apb(input w, input [11:0] a, input [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        // only the cycle timeout ends a stuck wait
        while (pready !== 1'b1) begin
            @(posedge clk_sys);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input [11:0] a, input [31:0] x);
        apb(1'b0, a, 32'h0);
        check("read", q, x);
    endtask
    task settle;
        repeat (4) @(posedge clk_sys);
    endtask
    task print_verdict;
        $display("compared %0d mismatched %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            fail_count = fail_count + 1;
            print_verdict;
        end
    end
    initial begin
        rstn <= 1'b0;
        repeat (10) @(posedge clk_sys);
        check("rst pix", panelPixelBus, 0);
        check("rst oe", gpioPinOe, 0);
        rstn <= 1'b1;
        rd(`LPM_GPIO_DIR_OFS, 0);
        rd(`LPM_CFG_OFS, 0);
        pixelDataIn <= 18'h3ffff;
        settle;
        check("off pix", panelPixelBus, 0);
        apb(1'b1, `LPM_GPIO_OUT_OFS, 32'h5);
        apb(1'b1, 12'h010, 32'hffffffff);
        check("bad wr", e, 1);
        rd(12'h010, 0);
        check("bad rd", e, 1);
        apb(1'b1, `LPM_GPIO_DIR_OFS, 32'h7);
        for (m = 0; m < 6; m = m + 1) begin
            c = modes[m];
            dm = c[1:0] == `LPM_TYPE_DIRECT;
            apb(1'b1, `LPM_CFG_OFS, 32'h0);
            apb(1'b1, `LPM_CFG_OFS, {26'h0, c});
            for (k = 0; k < 2; k = k + 1) begin
                v = k ? 12'h5a3 : 12'ha5c;
                {framePulseIn, linePulseIn, shiftClockIn, dataValidIn, secondShiftIn,
                    backplaneBiasIn, directStartPulseIn, directLatchPulseIn, sourceClockIn,
                    polarityReversalIn, gateDriverClockIn, panelPowerSaveIn} <= v;
                settle;
                check("pix", panelPixelBus, 18'h3ffff);
                check("frame", frameSyncOut, dm ? v[5] : v[11]);
                check("line", lineSyncOut, dm ? v[4] : v[10]);
                check("shift", pixelShiftOut, dm ? v[3] : v[9]);
                check("en", multiEnableOut, c[3] ? c[4] : c[1:0] == 1 ? v[8] : c[2:0] == 4 ? v[7] : v[6]);
                check("gpo", gpioPinOut, dm ? v[2:0] : 3'h5);
                check("oe", gpioPinOe, 3'h7);
            end
        end
        apb(1'b1, `LPM_CFG_OFS, 32'h22);
        rd(`LPM_CFG_OFS, 32'h21);
        apb(1'b1, `LPM_GPIO_DIR_OFS, 32'h0);
        extVal <= 3'h6;
        extEn <= 3'h7;
        settle;
        rd(`LPM_GPIO_IN_OFS, 32'h6);
        rd(`LPM_STATUS_OFS, 32'h2);
        extEn <= 3'h0;
        sc0 = shiftCount;
        // link clock of 320 ns: half period is four system clocks
        repeat (16) begin
            repeat (4) @(posedge clk_sys);
            shiftClockIn <= ~shiftClockIn;
        end
        settle;
        check("link", shiftCount - sc0, 8);
        rstn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        check("rst2 pix", panelPixelBus, 0);
        check("rst2 oe", gpioPinOe, 0);
        rstn <= 1'b1;
        rd(`LPM_CFG_OFS, 0);
        print_verdict;
    end
endmodule
